// File: inc/osdrt_defs.vh
// Purpose: Constants for the OSD register transfer and window block
// Assumes: 8-bit register port in the direct-bus register area
// Notes: Offsets are byte addresses inside the OSD register area
`ifndef OSDRT_DEFS_VH
`define OSDRT_DEFS_VH

// Register offsets
`define OSDRT_ADDR_W 4
`define OSDRT_OFS_CS4 4'h0
`define OSDRT_OFS_CS8 4'h1
`define OSDRT_OFS_CS12 4'h2
`define OSDRT_OFS_WTOP 4'h5
`define OSDRT_OFS_WBOT 4'h6
`define OSDRT_OFS_ETC 4'h9
`define OSDRT_OFS_DCTL 4'hd

// Display control field positions
`define OSDRT_BIT_PDEN 0
`define OSDRT_BIT_WEN 1
`define OSDRT_BIT_XREQ 2
`define OSDRT_BIT_FSEL 4
// Misc control field position
`define OSDRT_BIT_DSCAN 3

// Reset values
`define OSDRT_RST_BYTE 8'h00
`define OSDRT_RST_CS 24'h000000
`define OSDRT_RST_LINE 10'h000

// Size code meaning display off
`define OSDRT_SIZE_OFF 2'h0

`endif

// File: design/osdrt_sync_edge.v
// Purpose: Two-flop synchroniser with edge detection for one sync input
// Assumes: Input is asynchronous to clock
// Notes: Edge logic looks only at the second and third stages
`timescale 1ns/100ps
`default_nettype none
module osdrt_sync_edge (
  input wire clock,
  input wire rst,
  input wire asyncIn,
  output wire level,
  output wire fallPulse,
  output wire risePulse
);
  reg meta_ff;
  reg sync_ff;
  reg prev_ff;

  // Synchroniser stages and edge history
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      prev_ff <= 1'b1;
    end
    else
    begin
      meta_ff <= asyncIn;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // Edge pulses
  assign level = sync_ff;
  assign fallPulse = prev_ff & ~sync_ff;
  assign risePulse = ~prev_ff & sync_ff;
endmodule
`default_nettype wire

// File: design/osdrt_transfer_window.v
// Purpose: OSD staging registers, deferred transfer at line ends, window
// Assumes: Sync inputs active low and asynchronous; CPU port on clock
// Notes: Display-line status comes from the display circuit per scan line
//   Only display control reads back; every other offset reads zero
//   Window lines run from the top limit to just below the bottom limit
//   The scan line counter saturates if vertical sync goes missing
//   A pending request survives a later write with the request bit clear
// Function
// - Control registers sit in the direct-bus area with plain read and write.
// - Setting the request copies staged values at a non-display line end.
// - After the copy, hardware clears request and monitor flag itself.
// - Monitor flag in display control bit 2 reads one while pending.
// - Request outside display lines copies at next sync falling edge.
// - Request inside a display line copies at the edge ending it.
// - Immediate settings take effect at write with no deferred copy.
// - Page display enable switches the whole page on or off.
// - Window enable limits the page to lines between the limits.
// - Top and bottom limits are separate 8-bit written registers.
// - Normal scan places limits at value times two sync periods.
// - Double scan places limits at value times four sync periods.
// - Size code 00 is display off, other codes select a size.
`timescale 1ns/100ps
`default_nettype none
`include "osdrt_defs.vh"
module osdrt_transfer_window #(
  parameter LINE_W = 10
) (
  input wire clock,
  input wire rst,
  input wire [`OSDRT_ADDR_W-1:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrEn,
  input wire regRdEn,
  output reg [7:0] regRdData_ff,
  input wire horizontalSyncN,
  input wire verticalSyncN,
  input wire inDisplayLine,
  output reg [23:0] lineSizeCode_ff,
  output reg pageDisplayEnable_ff,
  output reg windowEnable_ff,
  output reg doubleScanSelect_ff,
  output reg freqSelect_ff,
  output reg windowActive_ff,
  output wire [11:0] lineDisplayOn
);
  // ----------------------------------------------------------------
  // Staging registers
  // ----------------------------------------------------------------
  reg [23:0] stCs_ff;
  reg [7:0] stTop_ff;
  reg [7:0] stBot_ff;
  reg stPden_ff;
  reg stWen_ff;
  reg transferReq_ff;
  reg [7:0] winTop_ff;
  reg [7:0] winBot_ff;
  reg [LINE_W-1:0] lineCnt_ff;
  reg lineBusy_ff;
  wire hsLevel;
  wire hsFall;
  wire vsLevel;
  wire vsFall;
  wire copyNow;
  wire [LINE_W-1:0] topLine;
  wire [LINE_W-1:0] botLine;
  // Decoded write strobes and the read mux value
  reg selCs4;
  reg selCs8;
  reg selCs12;
  reg selTop;
  reg selBot;
  reg selEtc;
  reg selDctl;
  reg [7:0] nxt_regRdData;

  // Sync inputs through two flops before edges are taken
  // Only the settled level and the edge pulses leave the synchronisers
  osdrt_sync_edge uHsync (
    .clock(clock),
    .rst(rst),
    .asyncIn(horizontalSyncN),
    .level(hsLevel),
    .fallPulse(hsFall),
    .risePulse()
  );
  osdrt_sync_edge uVsync (
    .clock(clock),
    .rst(rst),
    .asyncIn(verticalSyncN),
    .level(vsLevel),
    .fallPulse(vsFall),
    .risePulse()
  );

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // One-hot write strobes from the offset; an unmapped offset selects
  // nothing, so such a write is dropped
  always @*
  begin
    selCs4 = 1'b0;
    selCs8 = 1'b0;
    selCs12 = 1'b0;
    selTop = 1'b0;
    selBot = 1'b0;
    selEtc = 1'b0;
    selDctl = 1'b0;
    if (regAddr == `OSDRT_OFS_CS4)
      selCs4 = regWrEn;
    else if (regAddr == `OSDRT_OFS_CS8)
      selCs8 = regWrEn;
    else if (regAddr == `OSDRT_OFS_CS12)
      selCs12 = regWrEn;
    else if (regAddr == `OSDRT_OFS_WTOP)
      selTop = regWrEn;
    else if (regAddr == `OSDRT_OFS_WBOT)
      selBot = regWrEn;
    else if (regAddr == `OSDRT_OFS_ETC)
      selEtc = regWrEn;
    else if (regAddr == `OSDRT_OFS_DCTL)
      selDctl = regWrEn;
  end

  // Deferred values wait here until the next copy; a write during a
  // pending copy overwrites them, which software must avoid
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      stCs_ff <= `OSDRT_RST_CS;
      stTop_ff <= `OSDRT_RST_BYTE;
      stBot_ff <= `OSDRT_RST_BYTE;
      stPden_ff <= 1'b0;
      stWen_ff <= 1'b0;
    end
    else
    begin
      if (selCs4)
        stCs_ff[7:0] <= regWrData;
      if (selCs8)
        stCs_ff[15:8] <= regWrData;
      if (selCs12)
        stCs_ff[23:16] <= regWrData;
      if (selTop)
        stTop_ff <= regWrData;
      if (selBot)
        stBot_ff <= regWrData;
      if (selDctl)
      begin
        stPden_ff <= regWrData[`OSDRT_BIT_PDEN];
        stWen_ff <= regWrData[`OSDRT_BIT_WEN];
      end
    end
  end

  // Immediate fields act as soon as they are written
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      doubleScanSelect_ff <= 1'b0;
      freqSelect_ff <= 1'b0;
    end
    else
    begin
      if (selEtc)
        doubleScanSelect_ff <= regWrData[`OSDRT_BIT_DSCAN];
      if (selDctl)
        freqSelect_ff <= regWrData[`OSDRT_BIT_FSEL];
    end
  end

  // A new request wins over the clear of a finishing copy, and a zero
  // in the request bit never cancels a pending one
  always @(posedge clock or posedge rst)
  begin
    if (rst)
      transferReq_ff <= 1'b0;
    else if (selDctl && regWrData[`OSDRT_BIT_XREQ])
      transferReq_ff <= 1'b1;
    else if (copyNow)
      transferReq_ff <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Transfer timing
  // ----------------------------------------------------------------
  // Remember whether the current scan line belongs to a display line
  // A line that starts inside a display line stays busy to its last sync fall
  always @(posedge clock or posedge rst)
  begin
    if (rst)
      lineBusy_ff <= 1'b0;
    else if (hsFall)
      lineBusy_ff <= inDisplayLine;
    else if (inDisplayLine)
      lineBusy_ff <= 1'b1;
  end

  // Copy at the first sync falling edge that ends a line with no display
  // pending; a display line in progress defers to the edge ending it
  assign copyNow = transferReq_ff & hsFall & ~(inDisplayLine & lineBusy_ff);

  // All deferred values move together on one edge
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      lineSizeCode_ff <= `OSDRT_RST_CS;
      pageDisplayEnable_ff <= 1'b0;
      windowEnable_ff <= 1'b0;
      winTop_ff <= `OSDRT_RST_BYTE;
      winBot_ff <= `OSDRT_RST_BYTE;
    end
    else if (copyNow)
    begin
      lineSizeCode_ff <= stCs_ff;
      pageDisplayEnable_ff <= stPden_ff;
      windowEnable_ff <= stWen_ff;
      winTop_ff <= stTop_ff;
      winBot_ff <= stBot_ff;
    end
  end

  // Per-line on/off from size codes
  // Code 00 keeps a line dark even with the page switched on
  genvar gi;
  generate
    for (gi = 0; gi < 12; gi = gi + 1)
    begin : gLine
      assign lineDisplayOn[gi] = pageDisplayEnable_ff &
        (lineSizeCode_ff[2*gi+1:2*gi] != `OSDRT_SIZE_OFF);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Window
  // ----------------------------------------------------------------
  // Scan line counter restarted by vertical sync
  // Saturates rather than wraps when vertical sync goes missing
  always @(posedge clock or posedge rst)
  begin
    if (rst)
      lineCnt_ff <= `OSDRT_RST_LINE;
    else if (vsFall)
      lineCnt_ff <= `OSDRT_RST_LINE;
    else if (hsFall && lineCnt_ff != {LINE_W{1'b1}})
      lineCnt_ff <= lineCnt_ff + {{(LINE_W-1){1'b0}}, 1'b1};
  end

  // Limits scaled by two or four sync periods
  assign topLine = doubleScanSelect_ff ?
    {winTop_ff, 2'b00} : {1'b0, winTop_ff, 1'b0};
  assign botLine = doubleScanSelect_ff ?
    {winBot_ff, 2'b00} : {1'b0, winBot_ff, 1'b0};

  // Page visible inside the window, or everywhere with window off
  // With the window on, closed while vertical sync is low so a frame restart shows nothing stale
  always @(posedge clock or posedge rst)
  begin
    if (rst)
      windowActive_ff <= 1'b0;
    else if (!windowEnable_ff)
      windowActive_ff <= pageDisplayEnable_ff;
    else
      windowActive_ff <= pageDisplayEnable_ff & vsLevel &
        (lineCnt_ff >= topLine) & (lineCnt_ff < botLine);
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  // Read mux: display control status, every other offset reads zero
  always @*
  begin
    nxt_regRdData = `OSDRT_RST_BYTE;
    if (regAddr == `OSDRT_OFS_DCTL)
    begin
      nxt_regRdData[`OSDRT_BIT_PDEN] = pageDisplayEnable_ff;
      nxt_regRdData[`OSDRT_BIT_WEN] = windowEnable_ff;
      nxt_regRdData[`OSDRT_BIT_XREQ] = transferReq_ff;
      nxt_regRdData[`OSDRT_BIT_FSEL] = freqSelect_ff;
    end
  end

  // Read data is captured on a read strobe and held until the next one
  always @(posedge clock or posedge rst)
  begin
    if (rst)
      regRdData_ff <= `OSDRT_RST_BYTE;
    else if (regRdEn)
      regRdData_ff <= nxt_regRdData;
  end
endmodule
`default_nettype wire

// File: sim/osdrt_assertions.sv
// Purpose: Port-level checks for the OSD transfer and window block
// Assumes: One clock domain, asynchronous active-high reset
// Notes: Bound to the design top after the module
`timescale 1ns/100ps
`default_nettype none
module osdrt_assertions #(
  parameter LINE_W = 10
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regRdData_ff,
  input wire logic horizontalSyncN,
  input wire logic verticalSyncN,
  input wire logic inDisplayLine,
  input wire logic [23:0] lineSizeCode_ff,
  input wire logic pageDisplayEnable_ff,
  input wire logic windowEnable_ff,
  input wire logic doubleScanSelect_ff,
  input wire logic freqSelect_ff,
  input wire logic windowActive_ff,
  input wire logic [11:0] lineDisplayOn
);
  // ----
  // Checks
  // ----
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  AST_DSCAN: assert property (regWrEn && regAddr == 4'h9 |=>
    doubleScanSelect_ff == $past(regWrData[3])) else $error("double scan not immediate");
  AST_FSEL: assert property (regWrEn && regAddr == 4'hd |=>
    freqSelect_ff == $past(regWrData[4])) else $error("freq select not immediate");
  AST_LINEON: assert property (lineDisplayOn[0] ==
    (pageDisplayEnable_ff && lineSizeCode_ff[1:0] != 2'h0)) else $error("line on wrong");
  AST_COPYSIZE: assert property ($changed(lineSizeCode_ff) |->
    !horizontalSyncN) else $error("size codes changed outside sync low");
  AST_COPYEN: assert property ($changed({pageDisplayEnable_ff, windowEnable_ff}) |->
    !horizontalSyncN) else $error("enables changed outside sync low");
  AST_RDZERO: assert property (regRdEn && regAddr != 4'hd |=>
    regRdData_ff == 8'h00) else $error("unmapped read not zero");
  AST_RDHOLD: assert property (!regRdEn |=>
    $stable(regRdData_ff)) else $error("read data moved without read");
  AST_RDFSEL: assert property (regRdEn && regAddr == 4'hd |=>
    regRdData_ff[4] == $past(freqSelect_ff)) else $error("freq status wrong");
  AST_WINVS: assert property ((windowEnable_ff && !verticalSyncN) [*6] |->
    !windowActive_ff) else $error("window open in vertical sync");
endmodule
bind osdrt_transfer_window osdrt_assertions #(.LINE_W(LINE_W)) osdrt_assertions_inst (
  .clock, .rst, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData_ff, .horizontalSyncN,
  .verticalSyncN, .inDisplayLine, .lineSizeCode_ff, .pageDisplayEnable_ff, .windowEnable_ff,
  .doubleScanSelect_ff, .freqSelect_ff, .windowActive_ff, .lineDisplayOn);
`default_nettype wire

// File: sim/osdrt_video_source.sv
// Purpose: Video timing source for the OSD block
// Assumes: 64 clocks a line, sync low for the first 8 of them
// Notes: Line number counts sync falls since the vertical sync fall
`timescale 1ns/100ps
`default_nettype none
module osdrt_video_source (
  input wire logic clock,
  output logic horizontalSyncN,
  output logic verticalSyncN,
  output logic inDisplayLine,
  output logic [7:0] lineNo,
  output logic [5:0] phase
);
  initial
  begin
    lineNo = 8'h05;
    phase = 6'h00;
  end
  // Line and frame counters, vertical sync falls mid line 23
  always @(negedge clock)
  begin
    phase <= phase + 6'h01;
    if (phase == 6'h3f)
      lineNo <= lineNo + 8'h01;
    else if (lineNo == 8'h17 && phase == 6'h1f)
      lineNo <= 8'h00;
  end
  // Sync levels and the display-line status
  assign horizontalSyncN = (phase > 6'h07);
  assign verticalSyncN = !(lineNo == 8'h00 || (lineNo == 8'h01 && phase < 6'h20));
  assign inDisplayLine = (lineNo >= 8'h0e && lineNo <= 8'h11);
endmodule
`default_nettype wire

// File: sim/osd_register_transfer_and_window_tb_top.sv
// Purpose: Self-checking bench for the OSD transfer and window block
// Assumes: Video timing from osdrt_video_source
// Notes: Inputs change on the falling clock edge
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) \
  begin \
    checkCount++; \
    if ((a) !== (e)) \
    begin \
      miscompares++; \
      $display("[ERR] %0t mismatch got %h want %h", $time, a, e); \
    end \
  end
module osd_register_transfer_and_window_tb_top;
  // Starts low so no clock edge appears at time zero
  logic clock = 1'b0;
  logic rst, regWrEn, regRdEn, hsN, vsN, inDisp;
  logic pageEn, winEn, dScan, fSel, winAct;
  logic [3:0] regAddr;
  logic [7:0] regWrData, rdData, rdVal, lineNo;
  logic [23:0] sizeCode;
  logic [11:0] lineOn;
  logic [5:0] phase;
  int miscompares, checkCount, cycles;
  // Rows: address, data, expected double scan
  logic [3:0] rowA [5] = '{4'h9, 4'h0, 4'h9, 4'h5, 4'hc};
  logic [7:0] rowD [5] = '{8'h08, 8'h03, 8'h00, 8'h01, 8'h55};
  logic rowS [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
  osdrt_transfer_window #(.LINE_W(10)) osdrt_transfer_window_inst (.clock(clock), .rst(rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData_ff(rdData), .horizontalSyncN(hsN), .verticalSyncN(vsN), .inDisplayLine(inDisp),
    .lineSizeCode_ff(sizeCode), .pageDisplayEnable_ff(pageEn), .windowEnable_ff(winEn),
    .doubleScanSelect_ff(dScan), .freqSelect_ff(fSel), .windowActive_ff(winAct),
    .lineDisplayOn(lineOn));
  osdrt_video_source osdrt_video_source_inst (.clock(clock), .horizontalSyncN(hsN),
    .verticalSyncN(vsN), .inDisplayLine(inDisp), .lineNo(lineNo), .phase(phase));
  // ----
  // Clock, timeout and bus tasks
  // ----
  // Free-running clock; the bench never enters stop mode
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      conclude();
    end
  end
  task automatic conclude();
  begin
    $display("checks %0d miscompares %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
  begin
    @(negedge clock);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clock);
    regWrEn = 1'b0;
  end
  endtask
  task automatic rd(input logic [3:0] a);
  begin
    @(negedge clock);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clock);
    regRdEn = 1'b0;
    rdVal = rdData;
  end
  endtask
  task automatic toLine(input logic [7:0] l);
  begin
    @(negedge clock);
    while (!(lineNo == l && phase == 6'h0c))
      @(negedge clock);
  end
  endtask
  task automatic checkFrame(input int lo, input int hi);
  begin
    for (int l = 2; l < 24; l++)
    begin
      toLine(8'(l));
      `CHK(winAct, (l >= lo && l < hi))
    end
  end
  endtask
  // ----
  // Main sequence
  // ----
  initial
  begin
    rst = 1'b1;
    regAddr = 4'h0;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    repeat (3) @(negedge clock);
    rst = 1'b0;
    `CHK({sizeCode, pageEn, winEn, dScan, fSel, winAct}, 29'h0)
    for (int i = 0; i < 5; i++)
    begin
      wr(rowA[i], rowD[i]);
      `CHK(dScan, rowS[i])
      rd(rowA[i]);
      `CHK(rdVal, 8'h00)
      `CHK(sizeCode, 24'h0)
    end
    // Request outside display lines, copied at the next sync fall
    toLine(8'h03);
    wr(4'h0, 8'h01);
    wr(4'h5, 8'h01);
    wr(4'h6, 8'h03);
    wr(4'hd, 8'h1f);
    `CHK(fSel, 1'b1)
    repeat (4) @(negedge clock);
    rd(4'hd);
    `CHK(rdVal[2], 1'b1)
    `CHK({sizeCode, pageEn}, 25'h0)
    toLine(8'h04);
    `CHK({sizeCode, pageEn, winEn, lineOn[0]}, 27'hf)
    `CHK(lineOn, 12'h001)
    rd(4'hd);
    `CHK(rdVal[2:0], 3'h3)
    checkFrame(2, 6);
    wr(4'h9, 8'h08);
    checkFrame(4, 12);
    // Request inside a display line, held to its last sync fall
    toLine(8'h0e);
    wr(4'h0, 8'h02);
    wr(4'h1, 8'h30);
    wr(4'h2, 8'hc0);
    wr(4'hd, 8'h1d);
    while (sizeCode[1:0] != 2'h2)
      @(negedge clock);
    `CHK(lineNo, 8'h12)
    `CHK({winEn, pageEn, lineOn[0]}, 3'h3)
    `CHK(sizeCode, 24'hc03002)
    `CHK(lineOn, 12'h841)
    @(negedge clock);
    `CHK(winAct, 1'b1)
    // Mid-run reset drops a pending request and all applied state
    wr(4'hd, 8'h0d);
    rst = 1'b1;
    @(negedge clock);
    rst = 1'b0;
    `CHK({sizeCode, pageEn, winEn, dScan, fSel, winAct}, 29'h0)
    rd(4'hd);
    `CHK(rdVal, 8'h00)
    toLine(8'h14);
    `CHK({sizeCode, pageEn}, 25'h0)
    conclude();
  end
endmodule
`undef CHK
`default_nettype wire
